// >>> rtl/interrupt_ctrl_pkg.sv
package interrupt_ctrl_pkg;
    localparam int NUM_IRQ = 8;
    localparam int NUM_PERIPH = 24;
    localparam int NUM_SRC = 32;
    localparam int NUM_PRIO_REGS = 8;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [31:0] OFS_EXT_PRIO_0_3 = 32'hFFFF8348;
    localparam logic [31:0] OFS_EXT_PRIO_4_7 = 32'hFFFF834A;
    localparam logic [31:0] OFS_PERIPH_PRIO_1 = 32'hFFFF834C;
    localparam logic [31:0] OFS_PERIPH_PRIO_2 = 32'hFFFF834E;
    localparam logic [31:0] OFS_PERIPH_PRIO_3 = 32'hFFFF8350;
    localparam logic [31:0] OFS_PERIPH_PRIO_4 = 32'hFFFF8352;
    localparam logic [31:0] OFS_PERIPH_PRIO_5 = 32'hFFFF8354;
    localparam logic [31:0] OFS_PERIPH_PRIO_6 = 32'hFFFF8356;
    localparam logic [31:0] OFS_CONTROL = 32'hFFFF8358;
    localparam logic [31:0] OFS_FLAGS = 32'hFFFF835A;
    localparam logic [3:0] SEL_CONTROL = 4'h8;
    localparam logic [3:0] SEL_FLAGS = 4'h9;
    localparam logic [3:0] SEL_NONE = 4'hF;
    localparam logic [15:0] PRIO_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_RESET_NMI_LOW = 16'h0000;
    localparam logic [15:0] CONTROL_RESET_NMI_HIGH = 16'h8000;
    localparam int NMI_EDGE_BIT = 8;
    localparam int SENSE_LSB = 0;
    localparam logic [4:0] NMI_LEVEL = 5'h10;
    localparam logic [3:0] NMI_MASK = 4'hF;
    localparam logic [3:0] MASKED_LEVEL = 4'h0;
    localparam logic [5:0] NMI_SOURCE = 6'h20;
    localparam logic [31:0] STACK_STEP = 32'h00000004;

    typedef struct packed {
        logic [5:0] source;
        logic [4:0] level;
        logic [3:0] new_mask;
    } take_info_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PUSH_SR = 4'b0010,
        ST_PUSH_PC = 4'b0100,
        ST_END = 4'b1000
    } stack_state_type;
endpackage

// >>> rtl/interrupt_ctrl.sv
// Notes on behaviour
// R1 - forward only highest pending level to core
// R2 - sixteen levels per source, eight registers
// R3 - blocked interrupts and address errors stay latched
// R4 - delay slot decode blocks interrupts, address errors
// R5 - after register load/store, block interrupts only
// R6 - misaligned stacking raises address error afterwards
// R7 - no address errors during that error's stacking
// R8 - misaligned pushes still written, pointer minus four
// R9 - control bit mirrors live nonmaskable pin level
// R10 - notification pin signals pending interrupt
// R11 - external master may watch notify, return bus
// R12 - one nonmaskable plus eight external request inputs
// R13 - reset values; control top bit follows pin
// R14 - flag writes of one ignored, zero clears
// R15 - accept only above current mask level
// R16 - nonmaskable edge selectable, level 16, mask 15
// R17 - external pins low-level or falling-edge sensing
// R18 - priority zero means never forwarded
// R19 - notify low while eligible request pending
`timescale 1ns/1ps
`default_nettype none
module interrupt_ctrl
    import interrupt_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [33:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // request pins
    input wire logic nmi_pin,
    input wire logic [NUM_IRQ-1:0] ext_request_pins_n,
    input wire logic [NUM_PERIPH-1:0] periph_req,
    output logic request_notify_out_n,
    // core decode side
    input wire logic [3:0] mask_level_field,
    input wire logic decode_valid,
    input wire logic decode_in_slot,
    input wire logic decode_after_ctrl_ldst,
    input wire logic addr_err_req,
    output logic take_valid,
    output take_info_type take_info,
    output logic ae_take,
    // exception stacking
    input wire logic [31:0] stack_pointer_in,
    input wire logic [31:0] status_reg_in,
    input wire logic [31:0] pc_in,
    input wire logic stack_ready,
    input wire logic vector_done,
    output logic stack_wr,
    output logic [31:0] stack_addr,
    output logic [31:0] stack_data,
    output logic [31:0] stack_pointer_out,
    output logic exc_busy
);
    logic [15:0] prio_reg [NUM_PRIO_REGS];
    logic [15:0] control_reg;
    logic [NUM_IRQ-1:0] edge_flag_reg;
    logic [NUM_IRQ-1:0] read_one_reg;
    logic [NUM_IRQ-1:0] pin_prev_reg;
    logic nmi_prev_reg;
    logic nmi_pending_reg;
    logic ae_pending_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic notify_n_reg;
    stack_state_type state_reg;
    logic [31:0] sp_reg;
    logic stack_ae_req_reg;
    logic stack_ae_active_reg;
    logic take_valid_reg;
    take_info_type take_info_reg;
    logic ae_take_reg;

    logic [3:0] sel;
    logic wb_fire;
    logic wb_req;
    logic [15:0] control_read;
    logic [15:0] flags_read;
    logic [NUM_SRC-1:0] src_req;
    logic [3:0] best_level;
    logic [5:0] best_src;
    logic int_eligible;
    logic can_take_ae;
    logic can_take_int;
    logic nmi_edge;
    logic [NUM_IRQ-1:0] irq_fall;
    logic misaligned;

    function automatic logic [3:0] reg_select(input logic [33:0] adr);
        logic [31:0] idx;
        idx = adr[33:2];
        if (idx == OFS_EXT_PRIO_0_3) begin
            return 4'h0;
        end else if (idx == OFS_EXT_PRIO_4_7) begin
            return 4'h1;
        end else if (idx == OFS_PERIPH_PRIO_1) begin
            return 4'h2;
        end else if (idx == OFS_PERIPH_PRIO_2) begin
            return 4'h3;
        end else if (idx == OFS_PERIPH_PRIO_3) begin
            return 4'h4;
        end else if (idx == OFS_PERIPH_PRIO_4) begin
            return 4'h5;
        end else if (idx == OFS_PERIPH_PRIO_5) begin
            return 4'h6;
        end else if (idx == OFS_PERIPH_PRIO_6) begin
            return 4'h7;
        end else if (idx == OFS_CONTROL) begin
            return SEL_CONTROL;
        end else if (idx == OFS_FLAGS) begin
            return SEL_FLAGS;
        end else begin
            return SEL_NONE;
        end
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = d[7:0];
        end
        if (be[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction

    assign sel = reg_select(wb_adr_i);
    assign wb_req = wb_cyc_i && wb_stb_i;
    // write commits at the edge where the master sees ack
    assign wb_fire = wb_req && ack_reg;
    // control top bit is the live pin, which also yields the reset value
    assign control_read = control_reg | (nmi_pin ? CONTROL_RESET_NMI_HIGH : CONTROL_RESET_NMI_LOW); // R9 R13

    // level-sensed pins show the pin, edge-sensed pins show the latch
    always_comb begin
        flags_read = FLAGS_RESET;
        for (int i = 0; i < NUM_IRQ; i++) begin
            flags_read[i] = control_reg[SENSE_LSB+i] ? edge_flag_reg[i] : ~ext_request_pins_n[i]; // R17
        end
    end

    // wishbone slave, one wait state, unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req && !ack_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else if (wb_req && !ack_reg) begin
            if (sel < SEL_CONTROL) begin
                rdata_reg <= {16'h0000, prio_reg[sel[2:0]]};
            end else if (sel == SEL_CONTROL) begin
                rdata_reg <= {16'h0000, control_read};
            end else if (sel == SEL_FLAGS) begin
                rdata_reg <= {16'h0000, flags_read};
            end else begin
                rdata_reg <= 32'h00000000;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    generate
        for (genvar r = 0; r < NUM_PRIO_REGS; r++) begin : g_prio
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    prio_reg[r] <= PRIO_RESET; // R13
                end else if (wb_fire && wb_we_i && sel == 4'(r)) begin
                    prio_reg[r] <= lane_merge(prio_reg[r], wb_dat_i, wb_sel_i); // R2
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_reg <= CONTROL_RESET_NMI_LOW; // R13
        end else if (wb_fire && wb_we_i && sel == SEL_CONTROL) begin
            // top bit is read-only; it mirrors the pin
            control_reg <= lane_merge(control_reg, wb_dat_i, wb_sel_i) & ~CONTROL_RESET_NMI_HIGH;
        end
    end

    // pins are synchronous; previous samples give the edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_prev_reg <= {NUM_IRQ{1'b1}};
            nmi_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= ext_request_pins_n;
            nmi_prev_reg <= nmi_pin;
        end
    end

    assign irq_fall = pin_prev_reg & ~ext_request_pins_n;
    assign nmi_edge = control_reg[NMI_EDGE_BIT] ? (nmi_pin && !nmi_prev_reg) : (!nmi_pin && nmi_prev_reg); // R16

    // software may withdraw a flag only by writing zero after reading one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_one_reg <= {NUM_IRQ{1'b0}};
        end else if (wb_fire && sel == SEL_FLAGS) begin
            if (!wb_we_i) begin
                read_one_reg <= read_one_reg | (flags_read[NUM_IRQ-1:0] & edge_flag_reg);
            end else begin
                read_one_reg <= {NUM_IRQ{1'b0}};
            end
        end
    end

    generate
        for (genvar i = 0; i < NUM_IRQ; i++) begin : g_flag
            logic clr;
            assign clr = (wb_fire && wb_we_i && sel == SEL_FLAGS && wb_sel_i[0] && !wb_dat_i[i] && read_one_reg[i]) // R14
                || (take_valid_reg && take_info_reg.source == 6'(i));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    edge_flag_reg[i] <= 1'b0; // R13
                end else if (control_reg[SENSE_LSB+i] && irq_fall[i]) begin
                    // new edge beats a simultaneous clear
                    edge_flag_reg[i] <= 1'b1; // R17
                end else if (clr || !control_reg[SENSE_LSB+i]) begin
                    edge_flag_reg[i] <= 1'b0; // R17
                end
            end
            assign src_req[i] = control_reg[SENSE_LSB+i] ? edge_flag_reg[i] : ~ext_request_pins_n[i]; // R12
        end
    endgenerate

    assign src_req[NUM_SRC-1:NUM_IRQ] = periph_req;

    // strict compare keeps the lowest index on equal levels
    always_comb begin
        logic [3:0] lvl;
        lvl = MASKED_LEVEL;
        best_level = MASKED_LEVEL;
        best_src = 6'h00;
        for (int s = 0; s < NUM_SRC; s++) begin
            lvl = prio_reg[s/4][(15-4*(s%4)) -: 4];
            if (src_req[s] && lvl != MASKED_LEVEL && lvl > best_level) begin // R18
                best_level = lvl; // R1
                best_src = 6'(s);
            end
        end
    end

    assign int_eligible = nmi_pending_reg || (best_level > mask_level_field); // R15

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_pending_reg <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pending_reg <= 1'b1; // R16
        end else if (take_valid_reg && take_info_reg.source == NMI_SOURCE) begin
            nmi_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            notify_n_reg <= 1'b1;
        end else begin
            // released for a cycle after acceptance, gated by take_valid_reg
            notify_n_reg <= !(int_eligible && !take_valid_reg); // R10 R19
        end
    end

    assign request_notify_out_n = notify_n_reg;

    // acceptance gating at decode
    // a take in the cycle before stacking starts would be lost, so wait
    assign can_take_ae = state_reg == ST_IDLE && decode_valid && !decode_in_slot && ae_pending_reg // R4
        && !take_valid_reg && !ae_take_reg;
    assign can_take_int = state_reg == ST_IDLE && decode_valid && !decode_in_slot && !decode_after_ctrl_ldst // R4 R5
        && !can_take_ae && int_eligible && !take_valid_reg && !ae_take_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ae_pending_reg <= 1'b0;
        end else if (addr_err_req && !stack_ae_active_reg) begin
            ae_pending_reg <= 1'b1; // R3 R7
        end else if (can_take_ae) begin
            ae_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            take_valid_reg <= 1'b0;
            take_info_reg <= '0;
            ae_take_reg <= 1'b0;
        end else begin
            take_valid_reg <= can_take_int;
            ae_take_reg <= can_take_ae;
            if (can_take_int) begin
                if (nmi_pending_reg) begin
                    take_info_reg <= '{source: NMI_SOURCE, level: NMI_LEVEL, new_mask: NMI_MASK}; // R16
                end else begin
                    take_info_reg <= '{source: best_src, level: {1'b0, best_level}, new_mask: best_level}; // R1
                end
            end
        end
    end

    assign take_valid = take_valid_reg;
    assign take_info = take_info_reg;
    assign ae_take = ae_take_reg;

    // stacking engine: status then pc, each four below the last
    assign misaligned = sp_reg[1:0] != 2'b00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            sp_reg <= 32'h00000000;
            stack_ae_req_reg <= 1'b0;
            stack_ae_active_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (take_valid_reg || ae_take_reg) begin
                        state_reg <= ST_PUSH_SR;
                        sp_reg <= stack_pointer_in;
                    end
                end
                ST_PUSH_SR, ST_PUSH_PC: begin
                    if (stack_ready) begin
                        // write is issued even when misaligned
                        sp_reg <= sp_reg - STACK_STEP; // R8
                        state_reg <= (state_reg == ST_PUSH_SR) ? ST_PUSH_PC : ST_END;
                        if (misaligned && !stack_ae_active_reg) begin
                            stack_ae_req_reg <= 1'b1; // R6
                        end
                    end
                end
                ST_END: begin
                    if (vector_done) begin
                        if (stack_ae_req_reg) begin
                            // nested error stacking ignores further misalignment
                            stack_ae_req_reg <= 1'b0;
                            stack_ae_active_reg <= 1'b1; // R6 R7
                            state_reg <= ST_PUSH_SR;
                        end else begin
                            stack_ae_active_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign stack_wr = state_reg == ST_PUSH_SR || state_reg == ST_PUSH_PC;
    assign stack_addr = sp_reg - STACK_STEP; // R8
    // data is undefined on a misaligned push; zero is driven
    assign stack_data = misaligned ? 32'h00000000 : (state_reg == ST_PUSH_SR ? status_reg_in : pc_in);
    assign stack_pointer_out = sp_reg;
    assign exc_busy = state_reg != ST_IDLE;

    sequence s_push_pair;
        state_reg == ST_PUSH_SR && stack_ready ##1 state_reg == ST_PUSH_PC;
    endsequence

    a_slot_blocks_all: assert property (@(posedge clk) disable iff (rst) // R4
        decode_in_slot |-> !can_take_int && !can_take_ae) else $error("exception taken in delay slot");
    a_ldst_blocks_int: assert property (@(posedge clk) disable iff (rst) // R5
        decode_after_ctrl_ldst |=> !take_valid) else $error("interrupt taken after register load or store");
    a_level_above_mask: assert property (@(posedge clk) disable iff (rst) // R15
        can_take_int && !nmi_pending_reg |=> take_info.level > {1'b0, $past(mask_level_field)} && take_info.level != 5'h00)
        else $error("interrupt accepted at or below mask");
    a_nmi_sets_mask: assert property (@(posedge clk) disable iff (rst) // R16
        take_valid && take_info.source == NMI_SOURCE |-> take_info.new_mask == NMI_MASK && take_info.level == NMI_LEVEL)
        else $error("nonmaskable take with wrong mask");
    a_notify_pending: assert property (@(posedge clk) disable iff (rst) // R19
        $fell(request_notify_out_n) |-> $past(int_eligible)) else $error("notify without eligible request");
    a_ae_latched: assert property (@(posedge clk) disable iff (rst) // R3
        addr_err_req && !stack_ae_active_reg && decode_in_slot |=> ae_pending_reg) else $error("address error dropped");
    a_stack_step: assert property (@(posedge clk) disable iff (rst) // R8
        s_push_pair |-> sp_reg == $past(sp_reg) - STACK_STEP) else $error("stack pointer not stepped by four");
    a_no_nested_ae: assert property (@(posedge clk) disable iff (rst) // R7
        stack_ae_active_reg |-> !stack_ae_req_reg ##1 !stack_ae_req_reg) else $error("address error loop");
    a_misalign_raises: assert property (@(posedge clk) disable iff (rst) // R6
        stack_wr && stack_ready && misaligned && !stack_ae_active_reg |=> stack_ae_req_reg)
        else $error("misaligned stacking not flagged");
    a_nmi_bit_live: assert property (@(posedge clk) disable iff (rst) // R9
        control_read[15] == nmi_pin) else $error("control top bit not mirroring pin");
    a_ack_single: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
endmodule
`default_nettype wire

// >>> bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stacking bus side
    input wire logic stack_wr,
    input wire logic exc_busy,
    input wire logic slow,
    output logic stack_ready,
    output logic vector_done
);
    logic go_reg;
    logic [2:0] wait_reg;
    // slow bus grants every other cycle to stretch stacking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            go_reg <= 1'b0;
        end else begin
            go_reg <= slow ? ~go_reg : 1'b1;
        end
    end
    assign stack_ready = stack_wr & go_reg;
    // vector fetch ends a few cycles after the last push
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 3'h0;
            vector_done <= 1'b0;
        end else begin
            vector_done <= (wait_reg == 3'h3);
            wait_reg <= (exc_busy && !stack_wr && wait_reg != 3'h3) ? wait_reg + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/interrupt_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_ctrl_bench;
    import interrupt_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [33:0] wb_adr_i = 34'h0;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, stack_addr, stack_data, stack_pointer_out;
    logic wb_ack_o, request_notify_out_n, take_valid, ae_take;
    logic nmi_pin = 1'b0;
    logic [7:0] ext_request_pins_n = 8'hFF;
    logic [23:0] periph_req = 24'h0;
    logic [3:0] mask_level_field = 4'h0;
    logic decode_valid = 1'b0;
    logic decode_in_slot = 1'b0;
    logic decode_after_ctrl_ldst = 1'b0;
    logic addr_err_req = 1'b0;
    take_info_type take_info;
    logic [31:0] stack_pointer_in = 32'h2000;
    logic [31:0] status_reg_in = 32'h00F0;
    logic [31:0] pc_in = 32'h0400;
    logic stack_ready, vector_done, stack_wr, exc_busy;
    logic slow = 1'b0;
    logic [31:0] rd_q[$];
    logic [31:0] st_q[$];
    logic [31:0] sd_q[$];
    take_info_type tk_q[$];
    logic [15:0] prio [8];
    logic [31:0] req;
    logic [3:0] m;
    int err_count = 0;
    int n_tests = 0;
    int ae_seen = 0;
    int ae_exp = 0;
    int i, n, s, w, k;

    interrupt_ctrl dut_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .nmi_pin, .ext_request_pins_n, .periph_req, .request_notify_out_n,
        .mask_level_field, .decode_valid, .decode_in_slot, .decode_after_ctrl_ldst, .addr_err_req,
        .take_valid, .take_info, .ae_take, .stack_pointer_in, .status_reg_in, .pc_in, .stack_ready,
        .vector_done, .stack_wr, .stack_addr, .stack_data, .stack_pointer_out, .exc_busy);
    core_model model_u (.clk, .rst, .stack_wr, .exc_busy, .slow, .stack_ready, .vector_done);

    always #12.5 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wb(input logic wr, input logic [31:0] ofs, input logic [15:0] d, input logic [15:0] e);
        int j;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= wr;
        wb_adr_i <= {ofs, 2'b00};
        wb_dat_i <= {16'h0000, d};
        if (!wr) rd_q.push_back({16'h0000, e});
        for (j = 0; j < 20; j++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (j == 20) begin
            err_count++;
            give_verdict();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic exp_take(input logic [5:0] src, input logic [3:0] l, input logic [31:0] sp);
        tk_q.push_back({src, (src == NMI_SOURCE) ? NMI_LEVEL : {1'b0, l}, l});
        st_q.push_back(sp - STACK_STEP);
        st_q.push_back(sp - 2 * STACK_STEP);
        sd_q.push_back(sp[1:0] == 2'b00 ? status_reg_in : 32'h0);
        sd_q.push_back(sp[1:0] == 2'b00 ? pc_in : 32'h0);
    endtask

    // drops decode once the expected acceptances are in, so no second take sneaks in
    task automatic settle();
        int j;
        for (j = 0; j < 400; j++) begin
            @(posedge clk);
            if (tk_q.size() == 0 && ae_seen == ae_exp) decode_valid <= 1'b0;
            if (tk_q.size() == 0 && st_q.size() == 0 && ae_seen == ae_exp && exc_busy === 1'b0) break;
        end
        if (j == 400) begin
            err_count++;
            give_verdict();
        end
    endtask

    function automatic logic [3:0] lvl(input int x);
        return prio[x / 4][15 - 4 * (x % 4) -: 4];
    endfunction

    always @(negedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check("read data", wb_dat_o, rd_q.pop_front());
        if (take_valid === 1'b1 && tk_q.size() == 0) check("unexpected take", 32'h1, 32'h0);
        else if (take_valid === 1'b1) check("take_info", 32'(take_info), 32'(tk_q.pop_front()));
        if (stack_wr === 1'b1 && stack_ready === 1'b1) check("stack_addr", stack_addr, st_q.pop_front());
        if (stack_wr === 1'b1 && stack_ready === 1'b1) check("stack_data", stack_data, sd_q.pop_front());
        if (ae_take === 1'b1) ae_seen++;
    end

    initial begin
        void'($urandom(32'h692B));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 10; i++) wb(1'b0, OFS_EXT_PRIO_0_3 + 32'(2 * i), 16'h0000, 16'h0000);
        wb(1'b1, 32'hFFFF8360, 16'hFFFF, 16'h0000);
        wb(1'b0, 32'hFFFF8360, 16'h0000, 16'h0000);
        for (i = 0; i < 8; i++) begin
            prio[i] = 16'($urandom());
            wb(1'b1, OFS_EXT_PRIO_0_3 + 32'(2 * i), prio[i], 16'h0000);
            wb(1'b0, OFS_EXT_PRIO_0_3 + 32'(2 * i), 16'h0000, prio[i]);
        end
        for (n = 0; n < 10; n++) begin
            req = $urandom();
            m = 4'($urandom());
            w = -1;
            for (s = 0; s < NUM_SRC; s++) if (req[s] && lvl(s) > m && (w < 0 || lvl(s) > lvl(w))) w = s;
            @(posedge clk);
            ext_request_pins_n <= ~req[7:0];
            periph_req <= req[31:8];
            mask_level_field <= m;
            repeat (3) @(negedge clk);
            check("notify", 32'(request_notify_out_n), 32'(w < 0));
            @(posedge clk);
            decode_valid <= 1'b1;
            if (w >= 0) exp_take(6'(w), lvl(w), stack_pointer_in);
            settle();
            @(posedge clk);
            decode_valid <= 1'b0;
            ext_request_pins_n <= 8'hFF;
            periph_req <= 24'h0;
            repeat (2) @(posedge clk);
        end
        // delay slot holds off both kinds, then register load lets only the address error in
        prio[2] = 16'h5000;
        wb(1'b1, OFS_PERIPH_PRIO_1, 16'h5000, 16'h0000);
        @(posedge clk);
        mask_level_field <= 4'h2;
        periph_req <= 24'h000001;
        decode_valid <= 1'b1;
        decode_in_slot <= 1'b1;
        addr_err_req <= 1'b1;
        @(posedge clk);
        addr_err_req <= 1'b0;
        repeat (8) @(posedge clk);
        check("ae in slot", 32'(ae_seen), 32'h0);
        ae_exp = 1;
        st_q.push_back(32'h1FFC);
        st_q.push_back(32'h1FF8);
        sd_q.push_back(status_reg_in);
        sd_q.push_back(pc_in);
        decode_in_slot <= 1'b0;
        decode_after_ctrl_ldst <= 1'b1;
        settle();
        @(posedge clk);
        decode_valid <= 1'b1;
        repeat (6) @(posedge clk);
        exp_take(6'h08, 4'h5, 32'h2000);
        decode_after_ctrl_ldst <= 1'b0;
        settle();
        periph_req <= 24'h0;
        mask_level_field <= 4'h0;
        // falling-edge flag on pin 2
        prio[0] = 16'h0030;
        wb(1'b1, OFS_EXT_PRIO_0_3, 16'h0030, 16'h0000);
        wb(1'b1, OFS_CONTROL, 16'h8104, 16'h0000);
        wb(1'b0, OFS_CONTROL, 16'h0000, 16'h0104);
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            ext_request_pins_n <= 8'hFB;
            @(posedge clk);
            ext_request_pins_n <= 8'hFF;
            repeat (3) @(negedge clk);
            check("notify edge", 32'(request_notify_out_n), 32'h0);
        end
        wb(1'b0, OFS_FLAGS, 16'h0000, 16'h0004);
        wb(1'b1, OFS_FLAGS, 16'hFFFF, 16'h0000);
        wb(1'b0, OFS_FLAGS, 16'h0000, 16'h0004);
        wb(1'b1, OFS_FLAGS, 16'h0000, 16'h0000);
        wb(1'b0, OFS_FLAGS, 16'h0000, 16'h0000);
        check("notify clear", 32'(request_notify_out_n), 32'h1);
        @(posedge clk);
        ext_request_pins_n <= 8'hFB;
        @(posedge clk);
        ext_request_pins_n <= 8'hFF;
        decode_valid <= 1'b1;
        exp_take(6'h02, 4'h3, 32'h2000);
        settle();
        wb(1'b0, OFS_FLAGS, 16'h0000, 16'h0000);
        // rising nonmaskable edge with a misaligned stack, address error retried once
        @(posedge clk);
        nmi_pin <= 1'b1;
        mask_level_field <= 4'hF;
        stack_pointer_in <= 32'h1002;
        slow <= 1'b1;
        decode_valid <= 1'b1;
        exp_take(NMI_SOURCE, NMI_MASK, 32'h1002);
        st_q.push_back(32'h0FF6);
        st_q.push_back(32'h0FF2);
        sd_q.push_back(32'h0);
        sd_q.push_back(32'h0);
        for (k = 0; k < 400 && st_q.size() > 1; k++) @(posedge clk);
        addr_err_req <= 1'b1;
        @(posedge clk);
        addr_err_req <= 1'b0;
        settle();
        check("ae during retry", 32'(ae_seen), 32'h1);
        check("sp out", stack_pointer_out, 32'h0FF2);
        wb(1'b0, OFS_CONTROL, 16'h0000, 16'h8104);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, OFS_CONTROL, 16'h0000, 16'h8000);
        wb(1'b0, OFS_EXT_PRIO_0_3, 16'h0000, 16'h0000);
        // default select after reset is the falling edge
        @(posedge clk);
        nmi_pin <= 1'b0;
        repeat (3) @(negedge clk);
        check("notify nmi fall", 32'(request_notify_out_n), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
